// [logic/dq_ref_cal_pkg.sv]
/*
 Constants for the DQ input reference calibration control block:
 command pin encodings, reference mode register fields, reset values and timing counts.
 Assumes a 200 MHz core clock that samples the memory command pins.
*/
// Contract
// - Lower range value write loads trial code
// - Upper range value write loads trial code
// - Write with bit 7 clear ends calibration
// - Connectivity test forces half-supply reference
// - Entry by bit 7 set, bit 6 range
// - Bit 7 clear leaves bits 6:0 unchanged
// - Last accepted value stays after exit
package dq_ref_cal_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int ENTRY_DELAY_NS = 150;
	localparam int EXIT_DELAY_NS = 150;
	localparam int ENTRY_DELAY_CYC = (ENTRY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int EXIT_DELAY_CYC = (EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;

	// ==========================================================
	// Reference mode register fields
	localparam int ENABLE_BIT = 7;
	localparam int RANGE_BIT = 6;
	localparam int CODE_MSB = 5;
	localparam int CODE_W = 6;
	localparam logic RANGE_RESET = 1'h0;
	localparam logic [5:0] CODE_RESET = 6'h00;
	// Half-supply marker code shown while connectivity test holds the reference
	localparam logic [6:0] HALF_SUPPLY_SEL = 7'h7F;

	// ==========================================================
	// Command encodings {ras_n, cas_n, we_n} with chip select low and act_n high
	localparam logic [3:0] CMD_ACT_MASK = 4'h0;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_PRE = 3'h2;
	// Bank group / bank address selecting the reference mode register
	localparam logic BG0_REF_MR = 1'h1;
	localparam logic [1:0] BA_REF_MR = 2'h2;

	// ==========================================================
	// Sampled pin bundle layout, clock on top and test enable at bit 0
	localparam int PIN_W = 18;
	localparam int PIN_CLK = 17;
	localparam int PIN_CS_N = 16;
	localparam int PIN_ACT_N = 15;
	localparam int PIN_RCW_LSB = 12;
	localparam int PIN_BG0 = 11;
	localparam int PIN_BA_LSB = 9;
	localparam int PIN_ADDR_LSB = 1;
	localparam int PIN_TEN = 0;

	typedef enum logic [1:0] {
		ST_NORMAL,
		ST_ENTRY_WAIT,
		ST_CAL,
		ST_EXIT_WAIT
	} cal_state_e;
endpackage

// [logic/pin_sync.sv]
/*
 Two-stage synchroniser for a bundle of level inputs.
 Assumes each bit is stable for many destination clocks around the point of use.
*/
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// ==========================================================
	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// [logic/dq_ref_cal.sv]
/*
 DQ input reference calibration control, device side.
 Samples the memory clock and command pins with the core clock, decodes reference
 mode register writes and tracks calibration mode entry, value loads and exit.
 Assumes the memory clock is far slower than the core clock so pins are stable at edges.
*/
`timescale 1ns/10ps
module dq_ref_cal #(
	parameter int ENTRY_CYC = dq_ref_cal_pkg::ENTRY_DELAY_CYC,
	parameter int EXIT_CYC = dq_ref_cal_pkg::EXIT_DELAY_CYC
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic mem_clk_in,
	input wire logic cs_n_in,
	input wire logic act_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic bg0_in,
	input wire logic [1:0] ba_in,
	input wire logic [7:0] addr_in,
	input wire logic connectivity_test_enable_pin_in,
	output logic cal_active_out,
	output logic cal_busy_out,
	output logic [6:0] dq_input_reference_level_out,
	output logic ref_half_supply_out,
	output logic cmd_error_out
);
	// ==========================================================
	// Block state
	typedef struct packed {
		dq_ref_cal_pkg::cal_state_e state;
		logic [dq_ref_cal_pkg::CNT_W-1:0] cnt;
		logic clk_prev;
		logic range;
		logic [5:0] code;
		logic active;
		logic busy;
		logic [6:0] level;
		logic half;
		logic err;
	} cal_s;

	// Registered state and its next value
	cal_s cur_ff;
	cal_s nxt_cur;
	logic [dq_ref_cal_pkg::PIN_W-1:0] pins_raw;
	logic [dq_ref_cal_pkg::PIN_W-1:0] pins;

	// ==========================================================
	// Pin sampling
	// One bundle, clock on top; order must match the package layout
	assign pins_raw = {
		mem_clk_in,
		cs_n_in,
		act_n_in,
		ras_n_in,
		cas_n_in,
		we_n_in,
		bg0_in,
		ba_in,
		addr_in,
		connectivity_test_enable_pin_in
	};

	// Every pin passes two flops, so clock and command lag alike
	pin_sync #(
		.WIDTH(dq_ref_cal_pkg::PIN_W)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(pins_raw),
		.sync_out(pins)
	);

	// ==========================================================
	// Synchronised pin fields
	// Command fields are only trusted at a detected clock rise
	logic s_clk;
	logic s_cs_n;
	logic s_act_n;
	logic [2:0] s_rcw;
	logic s_bg0;
	logic [1:0] s_ba;
	logic [7:0] s_addr;
	logic s_ten;

	assign s_clk = pins[dq_ref_cal_pkg::PIN_CLK];
	assign s_cs_n = pins[dq_ref_cal_pkg::PIN_CS_N];
	assign s_act_n = pins[dq_ref_cal_pkg::PIN_ACT_N];
	assign s_rcw = pins[dq_ref_cal_pkg::PIN_RCW_LSB +: 3];
	assign s_bg0 = pins[dq_ref_cal_pkg::PIN_BG0];
	assign s_ba = pins[dq_ref_cal_pkg::PIN_BA_LSB +: 2];
	assign s_addr = pins[dq_ref_cal_pkg::PIN_ADDR_LSB +: 8];
	assign s_ten = pins[dq_ref_cal_pkg::PIN_TEN];

	// ==========================================================
	// Command decoding
	// Enable bit of a reference register write; clear means exit
	function automatic logic mr_enable(input logic [7:0] a);
		return a[dq_ref_cal_pkg::ENABLE_BIT];
	endfunction

	// Command that is legal while calibrating
	// NOP with chip select low is outside the legal set, so it is flagged
	function automatic logic cal_legal(input logic cs_n, input logic act_n, input logic [2:0] rcw,
		input logic is_ref_mr);
		logic ok;
		ok = 1'b0;
		if (cs_n) begin
			ok = 1'b1;
		end else if (!act_n) begin
			ok = 1'b1;
		end else begin
			case (rcw)
				dq_ref_cal_pkg::CMD_WR: ok = 1'b1;
				dq_ref_cal_pkg::CMD_RD: ok = 1'b1;
				dq_ref_cal_pkg::CMD_PRE: ok = 1'b1;
				dq_ref_cal_pkg::CMD_MRS: ok = is_ref_mr;
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction

	// ==========================================================
	// Command qualification
	logic edge_seen;
	logic cmd_valid;
	logic ref_mrs;

	// Rising memory clock edge qualifies one command
	assign edge_seen = s_clk & ~cur_ff.clk_prev;
	assign cmd_valid = edge_seen & ~s_cs_n;
	assign ref_mrs = cmd_valid & s_act_n & (s_rcw == dq_ref_cal_pkg::CMD_MRS)
		& (s_bg0 == dq_ref_cal_pkg::BG0_REF_MR) & (s_ba == dq_ref_cal_pkg::BA_REF_MR);

	// ==========================================================
	// Next-state logic
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.clk_prev = s_clk;
		nxt_cur.err = 1'b0;
		// One down-counter serves both the entry and the exit delay
		if (cur_ff.cnt != '0) begin
			nxt_cur.cnt = cur_ff.cnt - 1'b1;
		end
		case (cur_ff.state)
			dq_ref_cal_pkg::ST_NORMAL: begin
				// Entry write takes range only, code bits ignored
				if (ref_mrs && mr_enable(s_addr)) begin
					nxt_cur.range = s_addr[dq_ref_cal_pkg::RANGE_BIT];
					nxt_cur.state = dq_ref_cal_pkg::ST_ENTRY_WAIT;
					nxt_cur.cnt = dq_ref_cal_pkg::CNT_W'(ENTRY_CYC);
				end
			end
			dq_ref_cal_pkg::ST_ENTRY_WAIT: begin
				// Any command before the entry delay is a violation
				if (cmd_valid) begin
					nxt_cur.err = 1'b1;
				end
				if (cur_ff.cnt == '0) begin
					nxt_cur.state = dq_ref_cal_pkg::ST_CAL;
				end
			end
			dq_ref_cal_pkg::ST_CAL: begin
				if (edge_seen && !cal_legal(s_cs_n, s_act_n, s_rcw, ref_mrs)) begin
					nxt_cur.err = 1'b1;
				end
				if (ref_mrs && mr_enable(s_addr)) begin
					// Range is frozen; a mismatching range bit is flagged, not taken
					if (s_addr[dq_ref_cal_pkg::RANGE_BIT] != cur_ff.range) begin
						nxt_cur.err = 1'b1;
					end
					nxt_cur.code = s_addr[dq_ref_cal_pkg::CODE_MSB:0];
				end else if (ref_mrs) begin
					// Exit leaves range and code untouched
					nxt_cur.state = dq_ref_cal_pkg::ST_EXIT_WAIT;
					nxt_cur.cnt = dq_ref_cal_pkg::CNT_W'(EXIT_CYC);
				end
			end
			dq_ref_cal_pkg::ST_EXIT_WAIT: begin
				// Only deselects until the exit delay elapses
				if (cmd_valid) begin
					nxt_cur.err = 1'b1;
				end
				if (cur_ff.cnt == '0) begin
					nxt_cur.state = dq_ref_cal_pkg::ST_NORMAL;
				end
			end
			default: begin
				nxt_cur.state = dq_ref_cal_pkg::ST_NORMAL;
			end
		endcase
		nxt_cur.active = (nxt_cur.state != dq_ref_cal_pkg::ST_NORMAL);
		nxt_cur.busy = (nxt_cur.state == dq_ref_cal_pkg::ST_ENTRY_WAIT)
			|| (nxt_cur.state == dq_ref_cal_pkg::ST_EXIT_WAIT);
		// Test mode overrides whatever code is programmed
		nxt_cur.half = s_ten;
		nxt_cur.level = s_ten ? dq_ref_cal_pkg::HALF_SUPPLY_SEL : {nxt_cur.range, nxt_cur.code};
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			// Clock history starts low, matching the idle memory clock
			cur_ff <= '{
				state: dq_ref_cal_pkg::ST_NORMAL,
				cnt: '0,
				clk_prev: 1'b0,
				range: dq_ref_cal_pkg::RANGE_RESET,
				code: dq_ref_cal_pkg::CODE_RESET,
				active: 1'b0,
				busy: 1'b0,
				level: {dq_ref_cal_pkg::RANGE_RESET, dq_ref_cal_pkg::CODE_RESET},
				half: 1'b0,
				err: 1'b0
			};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ==========================================================
	// Outputs straight from the state register
	assign cal_active_out = cur_ff.active;
	assign cal_busy_out = cur_ff.busy;
	assign dq_input_reference_level_out = cur_ff.level;
	assign ref_half_supply_out = cur_ff.half;
	assign cmd_error_out = cur_ff.err;
endmodule

// [tb/dq_ref_cal_chk.sv]
/* Port checker for dq_ref_cal, bound to every instance.
 Assumes command pins hold steady well around each memory clock rise. */
`timescale 1ns/10ps
module dq_ref_cal_chk #(
	parameter int ENTRY_CYC = 30,
	parameter int EXIT_CYC = 30
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic mem_clk_in,
	input wire logic cs_n_in,
	input wire logic act_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic bg0_in,
	input wire logic [1:0] ba_in,
	input wire logic [7:0] addr_in,
	input wire logic connectivity_test_enable_pin_in,
	input wire logic cal_active_out,
	input wire logic cal_busy_out,
	input wire logic [6:0] dq_input_reference_level_out,
	input wire logic ref_half_supply_out,
	input wire logic cmd_error_out
);
	// ==========
	// Decode; margins cover the two-flop pin sync
	localparam int EN_LO = ENTRY_CYC - 4;
	localparam int EN_HI = ENTRY_CYC + 4;
	localparam int EX_LO = EXIT_CYC - 4;
	localparam int EX_HI = EXIT_CYC + 4;
	wire [7:0] a = addr_in;
	wire [6:0] lvl = dq_input_reference_level_out;
	wire ref_wr = !cs_n_in && act_n_in && !ras_n_in && !cas_n_in && !we_n_in && bg0_in && ba_in == 2'h2;
	wire legal = !act_n_in || ref_wr || {ras_n_in, cas_n_in, we_n_in} inside {3'h4, 3'h5, 3'h2};
	wire settled = cal_active_out && !cal_busy_out && !connectivity_test_enable_pin_in;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_take(c); $rose(mem_clk_in) && c; endsequence
	sequence s_exit_tail; ##[1:6] cal_busy_out ##[EX_LO:EX_HI] !cal_active_out; endsequence
	// ==========
	// Properties
	property p_entry; s_take(ref_wr && a[7] && !cal_active_out) |-> ##[1:6] (cal_busy_out && lvl[6] == a[6])
		##[EN_LO:EN_HI] !cal_busy_out; endproperty
	a_entry: assert property (p_entry) else $error("entry write mishandled");
	property p_value; s_take(ref_wr && a[7] && settled && a[6] == lvl[6]) |-> ##[1:6] lvl == a[6:0]; endproperty
	a_value: assert property (p_value) else $error("code not adopted");
	property p_range; s_take(ref_wr && a[7] && settled && a[6] != lvl[6]) |-> ##[1:6] cmd_error_out
		##[0:2] lvl == {~a[6], a[5:0]}; endproperty
	a_range: assert property (p_range) else $error("range change not refused");
	property p_exit; s_take(ref_wr && !a[7] && settled) |-> s_exit_tail; endproperty
	a_exit: assert property (p_exit) else $error("exit not completed");
	property p_keep; s_take(ref_wr && !a[7] && settled) |-> $stable(lvl) [*8]; endproperty
	a_keep: assert property (p_keep) else $error("exit write altered level");
	property p_illegal; s_take(!cs_n_in && !legal && settled) |-> ##[1:6] cmd_error_out; endproperty
	a_illegal: assert property (p_illegal) else $error("illegal command not flagged");
	property p_busy; s_take(!cs_n_in && cal_busy_out) ##2 cal_busy_out |-> ##1 cmd_error_out; endproperty
	a_busy: assert property (p_busy) else $error("command in wait not flagged");
	property p_half; connectivity_test_enable_pin_in [*4] |-> ##[0:3] (ref_half_supply_out && lvl == 7'h7F);
	endproperty
	a_half: assert property (p_half) else $error("test mode level not forced");
endmodule
bind dq_ref_cal dq_ref_cal_chk #(.ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC)) u_chk (.ref_clk_in, .rst_n_in,
	.mem_clk_in, .cs_n_in, .act_n_in, .ras_n_in, .cas_n_in, .we_n_in, .bg0_in, .ba_in, .addr_in,
	.connectivity_test_enable_pin_in, .cal_active_out, .cal_busy_out, .dq_input_reference_level_out,
	.ref_half_supply_out, .cmd_error_out);

// [tb/mem_cmd_model.sv]
/* Controller model: memory clock and command pins, one command per call.
 Assumes the caller runs on the core clock; cmd is {bg0, ba, cs_n, act_n, ras_n, cas_n, we_n}. */
`timescale 1ns/10ps
module mem_cmd_model (
	input wire logic ref_clk_in,
	output logic mem_clk_out,
	output logic [7:0] cmd_out,
	output logic [7:0] addr_out
);
	// Idle: clock low, deselected
	initial begin
		mem_clk_out = 1'b0;
		cmd_out = 8'hDF;
		addr_out = 8'h00;
	end
	// One 125 ns memory clock period; pins held 12 core cycles each side of the rise
	task automatic send(input logic [7:0] cmd, input logic [7:0] addr);
		@(posedge ref_clk_in);
		cmd_out <= cmd;
		addr_out <= addr;
		repeat (12) @(posedge ref_clk_in);
		mem_clk_out <= 1'b1;
		repeat (12) @(posedge ref_clk_in);
		mem_clk_out <= 1'b0;
		cmd_out <= {~cmd[7:5], 1'b1, ~cmd[3:0]};
		addr_out <= ~addr; // Stale pins never look valid
	endtask
endmodule

// [tb/tb.sv]
/* Self-checking bench for dq_ref_cal driven by the controller model.
 Assumes the checker binds itself from its own file. */
`timescale 1ns/10ps
module tb;
	localparam int DLY = 40;
	logic ref_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic test_pin = 1'b0;
	logic mem_clk_out, cal_active_out, cal_busy_out, ref_half_supply_out, cmd_error_out;
	logic [7:0] cmd_out, addr_out;
	logic [6:0] lvl;
	logic [5:0] code = 6'h00;
	logic [5:0] sweep[3] = '{6'h00, 6'h32, 6'h1F};
	logic [7:0] traffic[5] = '{8'hC7, 8'hCC, 8'hCD, 8'hCA, 8'hDF};
	int fail_count = 0;
	int num_checks = 0;
	int errs = 0;
	int err_exp = 0;
	// ==========
	// Clock, error pulse counter, parts
	always #2.5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) if (cmd_error_out === 1'b1) errs++;
	mem_cmd_model u_ctl (.ref_clk_in, .mem_clk_out, .cmd_out, .addr_out);
	dq_ref_cal #(.ENTRY_CYC(DLY), .EXIT_CYC(DLY)) u_dut (.ref_clk_in, .rst_n_in, .mem_clk_in(mem_clk_out),
		.cs_n_in(cmd_out[4]), .act_n_in(cmd_out[3]), .ras_n_in(cmd_out[2]), .cas_n_in(cmd_out[1]),
		.we_n_in(cmd_out[0]), .bg0_in(cmd_out[7]), .ba_in(cmd_out[6:5]), .addr_in(addr_out),
		.connectivity_test_enable_pin_in(test_pin), .cal_active_out, .cal_busy_out,
		.dq_input_reference_level_out(lvl), .ref_half_supply_out, .cmd_error_out);
	// ==========
	// Compare and close
	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic sc_normal;
		u_ctl.send(8'hC8, 8'h7F);
		u_ctl.send(8'hC9, 8'h00);
		chk({5'h0, cal_busy_out, cal_active_out}, 7'h00);
		chk(7'(errs), 7'(err_exp));
	endtask
	// Full calibration pass; ACT inside the entry wait must be flagged
	task automatic sc_cal(input logic r);
		u_ctl.send(8'hC8, {1'b1, r, 6'h2A});
		chk(lvl, {r, code});
		u_ctl.send(8'hC7, 8'h00);
		err_exp++;
		repeat (DLY) @(posedge ref_clk_in);
		chk({5'h0, cal_busy_out, cal_active_out}, 7'h01);
		foreach (sweep[i]) begin
			code = sweep[i];
			u_ctl.send(8'hC8, {1'b1, r, code});
			chk(lvl, {r, code});
			foreach (traffic[j]) u_ctl.send(traffic[j], 8'h55);
		end
		u_ctl.send(8'hC8, {1'b1, ~r, 6'h11});
		chk(lvl, {r, 6'h11});
		u_ctl.send(8'hC9, 8'h00);
		u_ctl.send(8'h08, 8'h80);
		err_exp += 3;
		chk(7'(errs), 7'(err_exp));
		code = 6'h24;
		u_ctl.send(8'hC8, {1'b1, r, code});
		u_ctl.send(8'hC8, {1'b0, ~r, ~code});
		chk(lvl, {r, code});
		repeat (DLY) @(posedge ref_clk_in);
		chk({5'h0, cal_busy_out, cal_active_out}, 7'h00);
		chk(lvl, {r, code});
	endtask
	task automatic sc_test;
		test_pin <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		chk(lvl, dq_ref_cal_pkg::HALF_SUPPLY_SEL);
		chk({6'h0, ref_half_supply_out}, 7'h01);
		test_pin <= 1'b0;
		repeat (6) @(posedge ref_clk_in);
		chk(lvl, {1'b1, code});
	endtask
	// ==========
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		sc_normal();
		sc_cal(1'b0);
		sc_cal(1'b1);
		sc_test();
		close_out();
	end
	initial begin
		repeat (30000) @(posedge ref_clk_in);
		fail_count++;
		close_out();
	end
endmodule
